// [core/mdra_decode.sv]
// address decoder: region, slot, aliasing and remap of slot zero
`timescale 1ns/1ns
`include "mdra_params.svh"
module mdra_decode
   import mdra_pkg::*;
#(
   parameter int FLASH_AW = 19,
   parameter int SRAM_AW = 17,
   parameter int ROM_AW = 12
) (
   input wire logic [31:0] addr,
   input wire logic remap,
   output mdra_tgt_e target,
   output logic [31:0] mem_addr,
   output logic undef
);
   logic [7:0] slot;
   logic [19:0] ofs;
   always_comb begin
      slot = addr[27:20];
      ofs = addr[19:0];
      target = MDRA_TGT_NONE;
      mem_addr = 32'h0000_0000;
      if (addr[31:28] == `MDRA_MEM_TOP) begin
         case (slot)
            `MDRA_SLOT_ZERO: target = remap ? MDRA_TGT_SRAM : MDRA_TGT_FLASH; // RULE6
            `MDRA_SLOT_ONE: target = MDRA_TGT_FLASH;
            `MDRA_SLOT_SRAM: target = MDRA_TGT_SRAM;
            `MDRA_SLOT_ROM: target = MDRA_TGT_ROM;
            default: target = MDRA_TGT_NONE; // RULE5
         endcase
      end
      // small memories ignore upper slot bits and repeat
      case (target)
         MDRA_TGT_FLASH: mem_addr = {12'h000, ofs & 20'((1 << FLASH_AW) - 1)}; // RULE3
         MDRA_TGT_SRAM: mem_addr = {12'h000, ofs & 20'((1 << SRAM_AW) - 1)}; // RULE3
         MDRA_TGT_ROM: mem_addr = {12'h000, ofs & 20'((1 << ROM_AW) - 1)}; // RULE3
         default: mem_addr = 32'h0000_0000;
      endcase
      // peripheral region passes on, the other fourteen regions abort
      undef = (addr[31:28] != `MDRA_PERIPH_TOP) && (target == MDRA_TGT_NONE); // RULE1 RULE4
   end
endmodule : mdra_decode

// [core/mdra_memory_controller.sv]
// memory decode, remap and abort status with an apb register slave
//
// Behaviour
// RULE1 - top four address bits pick memory or peripheral region; others abort
// RULE2 - eight more bits give each memory its own 1-Mbyte slot
// RULE3 - smaller memories repeat through their slot, upper slot bits ignored
// RULE4 - unmapped addresses in the memory region abort the requester
// RULE5 - slots four and up to the region end are undefined and abort
// RULE6 - slot zero shows flash from reset, sram after remap; sram stays at base
// RULE7 - writing one to the remap bit toggles slot zero; zero does nothing
// RULE8 - aborts come only from undefined address or misalignment
// RULE9 - the abort goes to every master; only the cpu acts on it
// RULE10 - each abort captures the full 32-bit address; register resets to zero
// RULE11 - each abort records access size: byte 00, half 01, word 10
// RULE12 - abort type: data read 00, data write 01, code fetch 10
// RULE13 - status bit 0 undefined cause, bit 1 misaligned cause, last abort only
// RULE14 - bits 16 to 18 name mac, dma, cpu as last abort source
// RULE15 - bits 24 to 26 keep earlier aborts per master; status read clears
// RULE16 - cpu data abort records the data address, not the instruction address
// RULE17 - misaligned word or half-word accesses are cancelled and aborted
// RULE18 - cpu instruction fetches skip the misalignment check
// RULE19 - aborted access touches nothing but the abort status and address
`timescale 1ns/1ns
`include "mdra_params.svh"
module mdra_memory_controller
   import mdra_pkg::*;
#(
   parameter int FLASH_AW = 19,
   parameter int SRAM_AW = 17,
   parameter int ROM_AW = 12
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire mdra_req_s bus_req,
   output logic abort_out,
   output mdra_mem_s mem_req,
   output logic remap_state
);
   ////////////////////////////////////////////////////////////////////////////
   localparam logic [2:0] SRC_MAC = 3'h1;
   localparam logic [2:0] SRC_DMA = 3'h2;
   localparam logic [2:0] SRC_CPU = 3'h4;

   mdra_tgt_e dec_target;
   logic [31:0] dec_addr;
   logic dec_undef;
   logic misal;
   logic hit_abort;

   mdra_decode #(
      .FLASH_AW(FLASH_AW),
      .SRAM_AW(SRAM_AW),
      .ROM_AW(ROM_AW)
   ) u_decode (
      .addr(bus_req.addr),
      .remap(remap_state),
      .target(dec_target),
      .mem_addr(dec_addr),
      .undef(dec_undef)
   );

   always_comb begin
      misal = 1'b0;
      if (!((bus_req.master == SRC_CPU) && (bus_req.kind == MDRA_TY_FETCH))) begin // RULE18
         if (bus_req.size == MDRA_SZ_WORD) begin
            misal = bus_req.addr[1:0] != 2'b00; // RULE17
         end else if (bus_req.size == MDRA_SZ_HALF) begin
            misal = bus_req.addr[0]; // RULE17
         end
      end
      hit_abort = bus_req.valid && (dec_undef || misal); // RULE8
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb slave, one wait state: pready rises in the second cycle of the access phase
   logic apb_acc;
   logic apb_wr;
   logic apb_rd;
   logic [3:0] ofs;
   logic ofs_ok;
   always_comb begin
      ofs = paddr[3:0];
      ofs_ok = (paddr[31:4] == 28'h000_0000) &&
         ((ofs == `MDRA_REMAP_OFS) || (ofs == `MDRA_ASR_OFS) || (ofs == `MDRA_AASR_OFS));
      apb_acc = psel && penable && !pready;
      apb_wr = apb_acc && pwrite && ofs_ok;
      apb_rd = apb_acc && !pwrite && ofs_ok;
   end

   ////////////////////////////////////////////////////////////////////////////
   logic remap_ff, nxt_remap;
   logic [1:0] cause_ff, nxt_cause;
   mdra_size_e size_ff, nxt_size;
   mdra_kind_e kind_ff, nxt_kind;
   logic [2:0] src_ff, nxt_src;
   logic [2:0] saved_ff, nxt_saved;
   logic [31:0] aaddr_ff, nxt_aaddr;
   logic abort_ff, nxt_abort;
   mdra_mem_s mem_ff, nxt_mem;
   logic [31:0] prdata_ff, nxt_prdata;
   logic pready_ff, nxt_pready;
   logic pslverr_ff, nxt_pslverr;
   logic [31:0] asr_val;

   always_comb begin
      asr_val = 32'h0000_0000;
      asr_val[`MDRA_UND_BIT] = cause_ff[0];
      asr_val[`MDRA_MIS_BIT] = cause_ff[1];
      asr_val[`MDRA_SZ_LSB +: 2] = size_ff;
      asr_val[`MDRA_TYP_LSB +: 2] = kind_ff;
      asr_val[`MDRA_SRC_LSB +: 3] = src_ff;
      asr_val[`MDRA_SAV_LSB +: 3] = saved_ff;
   end

   always_comb begin
      nxt_remap = remap_ff;
      nxt_cause = cause_ff;
      nxt_size = size_ff;
      nxt_kind = kind_ff;
      nxt_src = src_ff;
      nxt_saved = saved_ff;
      nxt_aaddr = aaddr_ff;
      nxt_abort = hit_abort; // RULE9
      nxt_prdata = 32'h0000_0000;
      nxt_pready = apb_acc;
      nxt_pslverr = apb_acc && !ofs_ok;
      nxt_mem = '0;
      // only a clean access reaches a memory
      if (bus_req.valid && !hit_abort) begin // RULE19
         nxt_mem.valid = dec_target != MDRA_TGT_NONE;
         nxt_mem.target = dec_target;
         nxt_mem.mem_addr = dec_addr; // RULE2
         nxt_mem.write = bus_req.kind == MDRA_TY_WRITE;
         nxt_mem.size = bus_req.size;
      end
      if (apb_wr && (ofs == `MDRA_REMAP_OFS) && pstrb[0] && pwdata[0]) begin
         nxt_remap = !remap_ff; // RULE7
      end
      if (apb_rd) begin
         case (ofs)
            `MDRA_ASR_OFS: nxt_prdata = asr_val;
            `MDRA_AASR_OFS: nxt_prdata = aaddr_ff;
            default: nxt_prdata = 32'h0000_0000;
         endcase
      end
      // status read clears saved flags; a same-cycle abort still sets them
      if (apb_rd && (ofs == `MDRA_ASR_OFS)) begin
         nxt_saved = 3'h0; // RULE15
      end
      if (hit_abort) begin
         nxt_cause = {misal, dec_undef}; // RULE13
         nxt_size = bus_req.size; // RULE11
         nxt_kind = bus_req.kind; // RULE12
         nxt_aaddr = bus_req.addr; // RULE10 RULE16
         nxt_src = bus_req.master; // RULE14
         // earlier abort of another master moves to saved once a newer one takes the source bits
         nxt_saved = nxt_saved | src_ff; // RULE15
         nxt_saved = nxt_saved & ~bus_req.master; // RULE15
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         remap_ff <= 1'b0; // RULE6
         cause_ff <= 2'b00;
         size_ff <= MDRA_SZ_BYTE;
         kind_ff <= MDRA_TY_READ;
         src_ff <= 3'h0;
         saved_ff <= 3'h0;
         aaddr_ff <= `MDRA_AASR_RST;
         abort_ff <= 1'b0;
         mem_ff <= '0;
         prdata_ff <= 32'h0000_0000;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else if (clk_en) begin
         remap_ff <= nxt_remap;
         cause_ff <= nxt_cause;
         size_ff <= nxt_size;
         kind_ff <= nxt_kind;
         src_ff <= nxt_src;
         saved_ff <= nxt_saved;
         aaddr_ff <= nxt_aaddr;
         abort_ff <= nxt_abort;
         mem_ff <= nxt_mem;
         prdata_ff <= nxt_prdata;
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
      end
   end

   always_comb begin
      prdata = prdata_ff;
      pready = pready_ff;
      pslverr = pslverr_ff;
      abort_out = abort_ff;
      mem_req = mem_ff;
      remap_state = remap_ff;
   end

   ////////////////////////////////////////////////////////////////////////////
   abort_follows_a: assert property (@(posedge core_clk) disable iff (rst) // RULE8
      clk_en && hit_abort |=> abort_out && aaddr_ff == $past(bus_req.addr))
      else $error("abort or address not captured");
   fetch_aligned_a: assert property (@(posedge core_clk) disable iff (rst) // RULE18
      clk_en && bus_req.valid && bus_req.master == SRC_CPU && bus_req.kind == MDRA_TY_FETCH
      && !dec_undef |=> !abort_out)
      else $error("cpu fetch aborted");
   word_misal_a: assert property (@(posedge core_clk) disable iff (rst) // RULE17
      clk_en && bus_req.valid && bus_req.kind != MDRA_TY_FETCH
      && bus_req.size == MDRA_SZ_WORD && bus_req.addr[1:0] != 2'b00
      |=> abort_out && cause_ff[1] && !mem_ff.valid)
      else $error("misaligned word not aborted");
   remap_toggle_a: assert property (@(posedge core_clk) disable iff (rst) // RULE7
      clk_en && apb_wr && ofs == `MDRA_REMAP_OFS && pstrb[0] && pwdata[0]
      |=> remap_state != $past(remap_state))
      else $error("remap did not toggle");
   remap_hold_a: assert property (@(posedge core_clk) disable iff (rst) // RULE7
      clk_en && !(apb_wr && ofs == `MDRA_REMAP_OFS && pwdata[0]) |=> $stable(remap_state))
      else $error("remap changed without command");
   slot_zero_a: assert property (@(posedge core_clk) disable iff (rst) // RULE6
      bus_req.valid && bus_req.addr[31:20] == 12'h000
      |-> dec_target == (remap_state ? MDRA_TGT_SRAM : MDRA_TGT_FLASH))
      else $error("slot zero mapping wrong");
   high_slot_a: assert property (@(posedge core_clk) disable iff (rst) // RULE5
      clk_en && bus_req.valid && bus_req.addr[31:28] == 4'h0 && bus_req.addr[27:22] != 6'h00
      |=> abort_out && cause_ff[0])
      else $error("undefined slot not aborted");
   region_a: assert property (@(posedge core_clk) disable iff (rst) // RULE1
      clk_en && bus_req.valid && bus_req.addr[31:28] != 4'h0 && bus_req.addr[31:28] != 4'hf
      |=> abort_out)
      else $error("undefined region not aborted");
   src_bits_a: assert property (@(posedge core_clk) disable iff (rst) // RULE14
      clk_en && hit_abort |=> src_ff == $past(bus_req.master) && size_ff == $past(bus_req.size))
      else $error("source or size not recorded");
   saved_clear_a: assert property (@(posedge core_clk) disable iff (rst) // RULE15
      clk_en && apb_rd && ofs == `MDRA_ASR_OFS && !hit_abort |=> saved_ff == 3'h0)
      else $error("saved flags not cleared by read");

   ////////////////////////////////////////////////////////////////////////////
   // decode, pass-through and status capture
   undef_cause_a: assert property (@(posedge core_clk) disable iff (rst) // RULE4
      clk_en && bus_req.valid && dec_undef |=> abort_out && cause_ff[0])
      else $error("unmapped address not aborted");
   periph_pass_a: assert property (@(posedge core_clk) disable iff (rst) // RULE1
      clk_en && bus_req.valid && bus_req.addr[31:28] == 4'hf && !misal
      |=> !abort_out && !mem_ff.valid)
      else $error("peripheral access aborted or reached a memory");
   slot_flash_a: assert property (@(posedge core_clk) disable iff (rst) // RULE2
      bus_req.valid && bus_req.addr[31:20] == 12'h001 |-> dec_target == MDRA_TGT_FLASH)
      else $error("slot one not flash");
   slot_sram_a: assert property (@(posedge core_clk) disable iff (rst) // RULE2
      bus_req.valid && bus_req.addr[31:20] == 12'h002 |-> dec_target == MDRA_TGT_SRAM)
      else $error("slot two not sram");
   slot_rom_a: assert property (@(posedge core_clk) disable iff (rst) // RULE2
      bus_req.valid && bus_req.addr[31:20] == 12'h003 |-> dec_target == MDRA_TGT_ROM)
      else $error("slot three not rom");
   sram_alias_a: assert property (@(posedge core_clk) disable iff (rst) // RULE3
      clk_en && bus_req.valid && !hit_abort && dec_target == MDRA_TGT_SRAM
      |=> mem_ff.mem_addr[31:SRAM_AW] == '0
      && mem_ff.mem_addr[SRAM_AW-1:0] == $past(bus_req.addr[SRAM_AW-1:0]))
      else $error("sram offset not aliased");
   flash_alias_a: assert property (@(posedge core_clk) disable iff (rst) // RULE3
      clk_en && bus_req.valid && !hit_abort && dec_target == MDRA_TGT_FLASH
      |=> mem_ff.mem_addr[31:FLASH_AW] == '0
      && mem_ff.mem_addr[FLASH_AW-1:0] == $past(bus_req.addr[FLASH_AW-1:0]))
      else $error("flash offset not aliased");
   half_misal_a: assert property (@(posedge core_clk) disable iff (rst) // RULE17
      clk_en && bus_req.valid && bus_req.kind != MDRA_TY_FETCH
      && bus_req.size == MDRA_SZ_HALF && bus_req.addr[0]
      |=> abort_out && cause_ff[1] && !mem_ff.valid)
      else $error("misaligned half-word not aborted");
   abort_pulse_a: assert property (@(posedge core_clk) disable iff (rst) // RULE9
      clk_en && !hit_abort |=> !abort_out)
      else $error("abort without cause");
   addr_hold_a: assert property (@(posedge core_clk) disable iff (rst) // RULE10
      clk_en && !hit_abort |=> $stable(aaddr_ff))
      else $error("abort address changed without abort");
   data_addr_a: assert property (@(posedge core_clk) disable iff (rst) // RULE16
      clk_en && hit_abort && bus_req.master == SRC_CPU && bus_req.kind != MDRA_TY_FETCH
      |=> aaddr_ff == $past(bus_req.addr))
      else $error("cpu data abort address wrong");
   kind_rec_a: assert property (@(posedge core_clk) disable iff (rst) // RULE12
      clk_en && hit_abort |=> kind_ff == $past(bus_req.kind))
      else $error("abort type not recorded");
   cause_rec_a: assert property (@(posedge core_clk) disable iff (rst) // RULE13
      clk_en && hit_abort
      |=> cause_ff[0] == $past(dec_undef) && cause_ff[1] == $past(misal))
      else $error("abort cause not recorded");
   clean_pass_a: assert property (@(posedge core_clk) disable iff (rst) // RULE19
      clk_en && bus_req.valid && !hit_abort && dec_target != MDRA_TGT_NONE
      |=> mem_ff.valid && !abort_out)
      else $error("clean access did not reach its memory");
   saved_excl_a: assert property (@(posedge core_clk) disable iff (rst) // RULE15
      clk_en && hit_abort |=> (saved_ff & src_ff) == 3'h0)
      else $error("saved flag repeats the last source");
   abort_only_a: assert property (@(posedge core_clk) disable iff (rst) // RULE19
      clk_en && hit_abort |=> !mem_ff.valid)
      else $error("aborted access reached a memory");
endmodule : mdra_memory_controller

// [core/mdra_params.svh]
// offsets, field positions, reset values and map constants of the memory decoder
`ifndef MDRA_PARAMS_SVH
`define MDRA_PARAMS_SVH
`define MDRA_REMAP_OFS 4'h0
`define MDRA_ASR_OFS 4'h4
`define MDRA_AASR_OFS 4'h8
`define MDRA_ASR_RST 32'h0000_0000
`define MDRA_AASR_RST 32'h0000_0000
`define MDRA_UND_BIT 0
`define MDRA_MIS_BIT 1
`define MDRA_SZ_LSB 8
`define MDRA_TYP_LSB 10
`define MDRA_SRC_LSB 16
`define MDRA_SAV_LSB 24
`define MDRA_MEM_TOP 4'h0
`define MDRA_PERIPH_TOP 4'hf
`define MDRA_SLOT_ZERO 8'h00
`define MDRA_SLOT_ONE 8'h01
`define MDRA_SLOT_SRAM 8'h02
`define MDRA_SLOT_ROM 8'h03
`endif

// [core/mdra_pkg.sv]
// types shared by the memory decoder
package mdra_pkg;
   typedef enum logic [1:0] {
      MDRA_SZ_BYTE = 2'b00,
      MDRA_SZ_HALF = 2'b01,
      MDRA_SZ_WORD = 2'b10
   } mdra_size_e;
   typedef enum logic [1:0] {
      MDRA_TY_READ = 2'b00,
      MDRA_TY_WRITE = 2'b01,
      MDRA_TY_FETCH = 2'b10
   } mdra_kind_e;
   typedef enum logic [1:0] {
      MDRA_TGT_NONE = 2'b00,
      MDRA_TGT_FLASH = 2'b01,
      MDRA_TGT_SRAM = 2'b10,
      MDRA_TGT_ROM = 2'b11
   } mdra_tgt_e;
   typedef struct packed {
      logic valid;
      logic [2:0] master;
      logic [31:0] addr;
      mdra_size_e size;
      mdra_kind_e kind;
   } mdra_req_s;
   typedef struct packed {
      logic valid;
      mdra_tgt_e target;
      logic [31:0] mem_addr;
      logic write;
      mdra_size_e size;
   } mdra_mem_s;
endpackage : mdra_pkg

// [dv/mdra_bus_master.sv]
// bus master model driving the internal request port of the memory decoder
`timescale 1ns/1ns
module mdra_bus_master
   import mdra_pkg::*;
(
   input wire logic core_clk,
   output mdra_req_s bus_req
);
   initial begin
      bus_req = '0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // one access a call; released master and address lines show inverted values so a stale request
   // can never pass for a live one
   task automatic issue(input logic [2:0] m, input logic [31:0] a, input mdra_size_e s,
                        input mdra_kind_e k);
      @(posedge core_clk);
      bus_req <= '{valid: 1'b1, master: m, addr: a, size: s, kind: k};
      @(posedge core_clk);
      bus_req <= '{valid: 1'b0, master: ~m, addr: ~a, size: s, kind: k};
   endtask : issue
endmodule : mdra_bus_master

// [dv/mdra_memory_controller_tb_top.sv]
// self-checking bench for the memory decoder, remap and abort status
`timescale 1ns/1ns
module mdra_memory_controller_tb_top
   import mdra_pkg::*;
;
   localparam int FA = 19;
   localparam int SA = 17;
   localparam int RA = 12;
   localparam mdra_size_e B = MDRA_SZ_BYTE;
   localparam mdra_size_e H = MDRA_SZ_HALF;
   localparam mdra_size_e W = MDRA_SZ_WORD;
   localparam mdra_kind_e RD = MDRA_TY_READ;
   localparam mdra_kind_e WR = MDRA_TY_WRITE;
   localparam mdra_kind_e FE = MDRA_TY_FETCH;
   localparam mdra_tgt_e NO = MDRA_TGT_NONE;
   localparam mdra_tgt_e FL = MDRA_TGT_FLASH;
   localparam mdra_tgt_e SR = MDRA_TGT_SRAM;
   localparam mdra_tgt_e RO = MDRA_TGT_ROM;
   logic core_clk;
   logic rst;
   logic psel;
   logic penable;
   logic pwrite;
   logic [31:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic abort_out;
   logic remap_state;
   mdra_req_s bus_req;
   mdra_mem_s mem_req;
   int n_fail = 0;
   int cmp_count = 0;
   int cyc = 0;
   logic [31:0] rd;
   logic er;
   logic [31:0] da [6] = '{32'h0000_0000, 32'h0018_0004, 32'h002e_0008, 32'h0030_1abc,
                           32'h0007_fffc, 32'hf000_0000};
   mdra_tgt_e dt [6] = '{FL, FL, SR, RO, FL, NO};
   mdra_memory_controller #(.FLASH_AW(FA), .SRAM_AW(SA), .ROM_AW(RA)) u_mdra_memory_controller (
      .core_clk(core_clk), .rst(rst), .clk_en(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .bus_req(bus_req), .abort_out(abort_out),
      .mem_req(mem_req), .remap_state(remap_state));
   mdra_bus_master u_mdra_bus_master (.core_clk(core_clk), .bus_req(bus_req));
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   // a hang counts as a mismatch
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_fail++;
         final_report();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // apb master; waits for pready with no assumed latency
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      // only pready or the bench timeout ends this wait
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask : apb
   task automatic acc(input logic [2:0] m, input logic [31:0] a, input mdra_size_e s,
                      input mdra_kind_e k, input logic ab, input mdra_tgt_e t);
      int aw;
      aw = (t == FL) ? FA : (t == SR) ? SA : RA;
      u_mdra_bus_master.issue(m, a, s, k);
      #1;
      chk(32'(abort_out), 32'(ab));
      chk(32'(mem_req.valid), 32'(!ab && t != NO));
      if (mem_req.valid === 1'b1) begin
         chk(32'(mem_req.target), 32'(t));
         chk(mem_req.mem_addr, a & ((32'h1 << aw) - 32'h1));
         chk(32'(mem_req.write), 32'(k == WR));
         chk(32'(mem_req.size), 32'(s));
      end
   endtask : acc
   task automatic final_report();
      if (n_fail == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : final_report
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      apb(0, 32'h4, 0);
      chk(rd, 32'h0);
      apb(0, 32'h8, 0);
      chk(rd, 32'h0);
      apb(0, 32'h0, 0);
      chk(32'(er), 32'h0);
      apb(1, 32'h100, 1);
      chk(32'(er) + 32'(remap_state), 32'h1);
      // decode table through every slot, aliasing and the peripheral region
      for (int i = 0; i < 6; i++) begin
         acc(3'b100, da[i], W, RD, 1'b0, dt[i]);
      end
      acc(3'b100, 32'h1000_0000, W, RD, 1'b1, NO);
      apb(0, 32'h4, 0);
      chk(rd, 32'h0004_0201);
      apb(0, 32'h8, 0);
      chk(rd, 32'h1000_0000);
      // same master first, so saved bits reflect only aborts after the read
      acc(3'b100, 32'h0040_0000, B, WR, 1'b1, NO);
      acc(3'b001, 32'h0050_0000, H, FE, 1'b1, NO);
      apb(0, 32'h4, 0);
      chk(rd, 32'h0401_0901);
      apb(0, 32'h8, 0);
      chk(rd, 32'h0050_0000);
      apb(0, 32'h4, 0);
      chk(rd, 32'h0001_0901);
      acc(3'b010, 32'h0020_0001, H, WR, 1'b1, NO);
      apb(0, 32'h4, 0);
      chk(rd, 32'h0102_0502);
      acc(3'b100, 32'h0000_0002, W, FE, 1'b0, FL);
      acc(3'b010, 32'h0000_0002, W, FE, 1'b1, NO);
      acc(3'b100, 32'h0020_0006, W, RD, 1'b1, NO);
      acc(3'b001, 32'h0020_0006, H, RD, 1'b0, SR);
      apb(0, 32'h8, 0);
      chk(rd, 32'h0020_0006);
      // remap toggles on one, ignores zero
      apb(1, 32'h0, 1);
      chk(32'(remap_state), 32'h1);
      acc(3'b100, 32'h0000_0010, W, RD, 1'b0, SR);
      acc(3'b100, 32'h0020_0010, W, RD, 1'b0, SR);
      apb(1, 32'h0, 0);
      chk(32'(remap_state), 32'h1);
      apb(1, 32'h0, 1);
      chk(32'(remap_state), 32'h0);
      acc(3'b100, 32'h0000_0010, W, RD, 1'b0, FL);
      final_report();
   end
endmodule : mdra_memory_controller_tb_top
